// ===== shared/lp_params.svh
// Timing, field and code constants for the power-down and calibration link
`ifndef LP_PARAMS_SVH
`define LP_PARAMS_SVH

// System clock period in ns
`define LP_CLK_NS 16'h000a
// Link clock half period in system clocks
`define LP_CK_HALF 16'h0008
// Latencies in link cycles; burst length in data beats, two per link cycle
`define LP_RD_LAT 16'h0003
`define LP_WR_LAT 16'h0001
`define LP_BURST 16'h0004
// Analog times in ns
`define LP_WREC_NS 16'h000f
`define LP_STRB_NS 16'h0006
`define LP_HOLD_NS 16'h0001
// Times given in link cycles
`define LP_MRW_CYC 16'h0005
`define LP_PULSE_CYC 16'h0003
`define LP_EXIT_CYC 16'h0002
`define LP_ZQS_CYC 16'h0024
`define LP_ZQL_CYC 16'h00b4
`define LP_ZQR_CYC 16'h0019
// Longest stay in power-down, link cycles
`define LP_PD_MAX_CYC 16'h03e8
// Mode register addresses and calibration opcodes
`define LP_MA_ZQ 6'h0a
`define LP_MA_RESET 6'h3f
`define LP_ZQ_OP_SHORT 8'h56
`define LP_ZQ_OP_LONG 8'hab
`define LP_ZQ_OP_RESET 8'hc3
// Command-address field positions
`define LP_CA_CODE 3:0
`define LP_CA_LOW3 2:0
`define LP_CA_AP 4
`define LP_CA_BANK 7:5
`define LP_CA_MA 9:4
// Low three code bits for no-operation and deep power-down
`define LP_LOW3_NOP 3'h7
`define LP_LOW3_DPD 3'h3

`endif

// ===== shared/lp_pkg.sv
// Types shared by both ends of the low-power memory link
package lp_pkg;

	// Command codes on the low command-address bits
	typedef enum logic [3:0] {
		LP_CA_MRW = 4'h0,
		LP_CA_WR = 4'h1,
		LP_CA_ACT = 4'h2,
		LP_CA_DPD = 4'h3,
		LP_CA_REFPB = 4'h4,
		LP_CA_RD = 4'h5,
		LP_CA_NOP = 4'h7,
		LP_CA_MRR = 4'h8,
		LP_CA_PRE = 4'hb,
		LP_CA_REFAB = 4'hc
	} lp_ca_e;

	// Requests from the controller user
	typedef enum logic [3:0] {
		REQ_RD = 4'h0,
		REQ_WR = 4'h1,
		REQ_WRA = 4'h2,
		REQ_ACT = 4'h3,
		REQ_PRE = 4'h4,
		REQ_PREA = 4'h5,
		REQ_REF = 4'h6,
		REQ_MRR = 4'h7,
		REQ_MRW = 4'h8,
		REQ_ZQS = 4'h9,
		REQ_ZQL = 4'ha,
		REQ_ZQR = 4'hb,
		REQ_PDE = 4'hc,
		REQ_PDX = 4'hd,
		REQ_DPDE = 4'he,
		REQ_DPDX = 4'hf
	} lp_req_e;

	// Controller states
	typedef enum logic [2:0] {
		C_RUN = 3'h0,
		C_PD = 3'h1,
		C_PDX = 3'h2,
		C_ZQ = 3'h3,
		C_DPD = 3'h4
	} lp_cst_e;

	// Memory states
	typedef enum logic [1:0] {
		D_IDLE = 2'h0,
		D_PD = 2'h1,
		D_DPD = 2'h2
	} lp_dst_e;

endpackage

// ===== shared/lp_link_if.sv
// Link between controller and memory: clock, clock enable, select, command-address
`timescale 1ns/1ps
interface lp_link_if;
	logic ck;
	logic cke;
	logic cs_n;
	logic [9:0] ca;
	logic [7:0] op;
	modport ctrl (output ck, output cke, output cs_n, output ca, output op);
	modport mem (input ck, input cke, input cs_n, input ca, input op);
endinterface

// ===== design/lp_sync_edge.sv
// Two-flop synchroniser for a bus of link pins, with rising edge of bit 0
`timescale 1ns/1ps
module lp_sync_edge #(
	parameter int W = 21
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Asynchronous pins and synchronised copy
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic rise
);
	logic [W-1:0] meta;
	logic q0_d;

	if (W < 1) begin : g_bad
		$error("lp_sync_edge: width must be at least one");
	end

	// Two stages per bit
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (rst) begin
				meta[i] <= 1'b0;
				q[i] <= 1'b0;
			end else begin
				meta[i] <= d[i];
				q[i] <= meta[i];
			end
		end
	end

	// Edge detect on the second stage only
	always_ff @(posedge clk) begin
		if (rst) begin
			q0_d <= 1'b0;
		end else begin
			q0_d <= q[0];
		end
	end
	assign rise = q[0] & ~q0_d;
endmodule // lp_sync_edge

// ===== design/lp_mem.sv
// Memory end: power-down, deep power-down and calibration tracking
`timescale 1ns/1ps
`include "lp_params.svh"
module lp_mem #(
	parameter int PULSE_CYC = `LP_PULSE_CYC,
	parameter int EXIT_CYC = `LP_EXIT_CYC,
	parameter int ZQS_CYC = `LP_ZQS_CYC,
	parameter int ZQL_CYC = `LP_ZQL_CYC,
	parameter int ZQR_CYC = `LP_ZQR_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link
	lp_link_if.mem link,
	// Status
	output logic pd,
	output logic pd_active,
	output logic dpd,
	output logic zq_busy,
	output logic contents_lost,
	output logic [7:0] open_banks,
	output logic err
);
	logic [20:0] s;
	logic ck_rise;
	logic cke;
	logic csn;
	logic [9:0] ca;
	logic [7:0] op;
	logic is_nop;
	lp_pkg::lp_dst_e state, next_state;
	logic cke_prev, next_cke_prev;
	logic act_pd, next_act_pd;
	logic [15:0] zq_cnt, next_zq_cnt;
	logic [15:0] pcnt, next_pcnt;
	logic [15:0] xp_cnt, next_xp_cnt;
	logic [7:0] open, next_open;
	logic lost, next_lost;
	logic next_err;

	if (PULSE_CYC < 1 || EXIT_CYC < 1 || ZQL_CYC > 65535) begin : g_bad
		$error("lp_mem: timing counts out of range");
	end

	// Link pins into the system clock
	lp_sync_edge #(.W(21)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({link.op, link.ca, link.cs_n, link.cke, link.ck}),
		.q(s),
		.rise(ck_rise)
	);
	assign cke = s[1];
	assign csn = s[2];
	assign ca = s[12:3];
	assign op = s[20:13];
	assign is_nop = csn || (ca[`LP_CA_LOW3] == `LP_LOW3_NOP);

	// Next state on each sampled link edge
	always_comb begin
		next_state = state;
		next_cke_prev = cke_prev;
		next_act_pd = act_pd;
		next_zq_cnt = zq_cnt;
		next_pcnt = pcnt;
		next_xp_cnt = xp_cnt;
		next_open = open;
		next_lost = lost;
		next_err = 1'b0;
		if (ck_rise) begin
			next_cke_prev = cke;
			if (zq_cnt != 16'h0000) begin
				next_zq_cnt = zq_cnt - 16'h0001;
			end
			if (pcnt != 16'h0000) begin
				next_pcnt = pcnt - 16'h0001;
			end
			if (xp_cnt != 16'h0000) begin
				next_xp_cnt = xp_cnt - 16'h0001;
			end
			if (zq_cnt != 16'h0000 && (!is_nop || !cke)) begin
				next_err = 1'b1;
			end
			case (state)
				lp_pkg::D_IDLE: begin
					if (cke_prev && !cke) begin
						if (csn) begin
							next_state = lp_pkg::D_PD;
							next_act_pd = |open;
							next_pcnt = 16'(PULSE_CYC - 1);
						end else if (ca[`LP_CA_LOW3] == `LP_LOW3_DPD) begin
							next_state = lp_pkg::D_DPD;
							next_lost = 1'b1;
							next_open = 8'h00;
						end else begin
							next_err = 1'b1;
						end
					end else if (cke && !is_nop) begin
						if (xp_cnt != 16'h0000) begin
							next_err = 1'b1;
						end
						case (ca[`LP_CA_CODE])
							lp_pkg::LP_CA_ACT: next_open[ca[`LP_CA_BANK]] = 1'b1;
							lp_pkg::LP_CA_PRE: begin
								if (ca[`LP_CA_AP]) begin
									next_open = 8'h00;
								end else begin
									next_open[ca[`LP_CA_BANK]] = 1'b0;
								end
							end
							lp_pkg::LP_CA_WR: begin
								if (ca[`LP_CA_AP]) begin
									next_open[ca[`LP_CA_BANK]] = 1'b0;
								end
							end
							lp_pkg::LP_CA_MRW: begin
								if (ca[`LP_CA_MA] == `LP_MA_ZQ && open != 8'h00) begin
									next_err = 1'b1;
								end else if (ca[`LP_CA_MA] == `LP_MA_ZQ) begin
									case (op)
										`LP_ZQ_OP_SHORT: next_zq_cnt = 16'(ZQS_CYC);
										`LP_ZQ_OP_LONG: next_zq_cnt = 16'(ZQL_CYC);
										`LP_ZQ_OP_RESET: next_zq_cnt = 16'(ZQR_CYC);
										default: next_zq_cnt = zq_cnt;
									endcase
								end else if (ca[`LP_CA_MA] == `LP_MA_RESET) begin
									next_lost = 1'b0;
								end
							end
							default: next_open = open;
						endcase
					end
				end
				lp_pkg::D_PD: begin
					if (cke) begin
						if (pcnt != 16'h0000) begin
							next_err = 1'b1;
						end
						if (csn) begin
							next_state = lp_pkg::D_IDLE;
							next_xp_cnt = 16'(EXIT_CYC - 1);
						end else begin
							next_err = 1'b1;
						end
					end
				end
				lp_pkg::D_DPD: begin
					if (cke && csn) begin
						next_state = lp_pkg::D_IDLE;
					end
				end
				default: next_state = lp_pkg::D_IDLE;
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= lp_pkg::D_IDLE;
			cke_prev <= 1'b0;
			act_pd <= 1'b0;
			zq_cnt <= 16'h0000;
			pcnt <= 16'h0000;
			xp_cnt <= 16'h0000;
			open <= 8'h00;
			lost <= 1'b0;
			err <= 1'b0;
		end else begin
			state <= next_state;
			cke_prev <= next_cke_prev;
			act_pd <= next_act_pd;
			zq_cnt <= next_zq_cnt;
			pcnt <= next_pcnt;
			xp_cnt <= next_xp_cnt;
			open <= next_open;
			lost <= next_lost;
			err <= next_err;
		end
	end

	// Status outputs
	assign pd = (state == lp_pkg::D_PD);
	assign pd_active = pd && act_pd;
	assign dpd = (state == lp_pkg::D_DPD);
	assign zq_busy = (zq_cnt != 16'h0000);
	assign contents_lost = lost;
	assign open_banks = open;
endmodule // lp_mem

// ===== design/lp_ctrl.sv
// Controller end: link clock, command timing, power-down and calibration
`timescale 1ns/1ps
`include "lp_params.svh"
module lp_ctrl #(
	parameter int CK_HALF = `LP_CK_HALF,
	parameter int RD_LAT = `LP_RD_LAT,
	parameter int WR_LAT = `LP_WR_LAT,
	parameter int BURST = `LP_BURST,
	parameter int WREC_NS = `LP_WREC_NS,
	parameter int STRB_NS = `LP_STRB_NS,
	parameter int HOLD_NS = `LP_HOLD_NS,
	parameter int MRW_CYC = `LP_MRW_CYC,
	parameter int PULSE_CYC = `LP_PULSE_CYC,
	parameter int EXIT_CYC = `LP_EXIT_CYC,
	parameter int ZQS_CYC = `LP_ZQS_CYC,
	parameter int ZQL_CYC = `LP_ZQL_CYC,
	parameter int ZQR_CYC = `LP_ZQR_CYC,
	parameter int PD_MAX_CYC = `LP_PD_MAX_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// User requests
	input wire logic req_valid,
	input wire lp_pkg::lp_req_e req_cmd,
	input wire logic [2:0] req_bank,
	input wire logic [5:0] req_addr,
	input wire logic [7:0] req_op,
	output logic req_ready,
	// Shared calibration resistor
	input wire logic zq_other_busy,
	output logic zq_busy,
	// Status
	output logic in_pd,
	output logic in_dpd,
	output logic need_init,
	output logic [7:0] open_banks,
	// Link
	lp_link_if.ctrl link
);
	// Link cycle period in ns and derived gaps in link cycles
	localparam int TCK_NS = 2 * CK_HALF * `LP_CLK_NS;
	localparam int STRB_CYC = (STRB_NS + TCK_NS - 1) / TCK_NS;
	localparam int WR_CYC = (WREC_NS + TCK_NS - 1) / TCK_NS;
	localparam int IH_RAW = (HOLD_NS + TCK_NS - 1) / TCK_NS;
	localparam int IH_CYC = (IH_RAW < 1) ? 1 : IH_RAW;
	localparam int RD_GAP = RD_LAT + STRB_CYC + BURST / 2 + 1;
	localparam int WR_GAP = WR_LAT + 1 + BURST / 2 + WR_CYC;
	localparam int WRA_GAP = WR_GAP + 1;
	localparam int PDX_CYC = (EXIT_CYC > PULSE_CYC) ? EXIT_CYC : PULSE_CYC;
	localparam int DW = $clog2(2 * CK_HALF);

	if (CK_HALF < 2 || PULSE_CYC < 1 || EXIT_CYC < 1 || MRW_CYC < 1
			|| ZQS_CYC < 1 || ZQR_CYC < 1 || ZQL_CYC > 65535 || PD_MAX_CYC > 65535) begin : g_bad
		$error("lp_ctrl: parameter out of range");
	end

	logic [DW-1:0] div, next_div;
	logic ck, next_ck;
	logic tick;
	lp_pkg::lp_cst_e state, next_state;
	logic [15:0] guard, next_guard;
	logic [15:0] cnt, next_cnt;
	logic [15:0] pdt, next_pdt;
	logic cke, next_cke;
	logic cs_n, next_cs_n;
	logic [9:0] ca, next_ca;
	logic [7:0] op, next_op;
	logic [7:0] open, next_open;
	logic init_due, next_init_due;
	logic zq_on, next_zq_on;
	logic accept;
	logic [15:0] load;
	logic [15:0] guard_dec;

	// Link clock divider; ck falls when tick is seen
	always_comb begin
		next_div = (div == DW'(2 * CK_HALF - 1)) ? '0 : div + DW'(1);
		next_ck = (next_div < DW'(CK_HALF));
	end
	assign tick = (div == DW'(CK_HALF - 1));

	always_ff @(posedge clk) begin
		if (rst) begin
			div <= '0;
			ck <= 1'b0;
		end else begin
			div <= next_div;
			ck <= next_ck;
		end
	end

	// Which requests may be taken at this link cycle
	always_comb begin
		req_ready = 1'b0;
		if (tick) begin
			case (state)
				lp_pkg::C_RUN: begin
					case (req_cmd)
						lp_pkg::REQ_PDE: req_ready = (guard == 16'h0000);
						lp_pkg::REQ_DPDE: req_ready = (guard == 16'h0000) && (open == 8'h00);
						lp_pkg::REQ_ZQS, lp_pkg::REQ_ZQL: begin
							req_ready = (open == 8'h00) && !zq_other_busy && !init_due;
						end
						// Reset calibration may overlap other devices
						lp_pkg::REQ_ZQR: req_ready = (open == 8'h00) && !init_due;
						lp_pkg::REQ_MRW: req_ready = (open == 8'h00);
						lp_pkg::REQ_PDX, lp_pkg::REQ_DPDX: req_ready = 1'b0;
						default: req_ready = !init_due;
					endcase
				end
				lp_pkg::C_PD: req_ready = (req_cmd == lp_pkg::REQ_PDX) && (cnt == 16'h0000);
				// enable low pulse kept in deep too
				lp_pkg::C_DPD: req_ready = (req_cmd == lp_pkg::REQ_DPDX) && (cnt == 16'h0000);
				default: req_ready = 1'b0;
			endcase
		end
	end
	assign accept = req_valid && req_ready;
	assign guard_dec = (guard != 16'h0000) ? guard - 16'h0001 : 16'h0000;

	// Command sequencing, one step per link cycle
	always_comb begin
		next_state = state;
		next_guard = guard;
		next_cnt = cnt;
		next_pdt = pdt;
		next_cke = cke;
		next_cs_n = cs_n;
		next_ca = ca;
		next_op = op;
		next_open = open;
		next_init_due = init_due;
		next_zq_on = zq_on;
		load = 16'h0000;
		if (tick) begin
			next_cs_n = 1'b1;
			next_ca = {6'h00, lp_pkg::LP_CA_NOP};
			next_op = 8'h00;
			next_guard = guard_dec;
			if (cnt != 16'h0000) begin
				next_cnt = cnt - 16'h0001;
			end
			case (state)
				lp_pkg::C_RUN: begin
					if (accept) begin
						next_cs_n = 1'b0;
						next_ca = {2'b00, req_bank, 1'b0, lp_pkg::LP_CA_NOP};
						case (req_cmd)
							lp_pkg::REQ_RD: begin
								next_ca[`LP_CA_CODE] = lp_pkg::LP_CA_RD;
								load = 16'(RD_GAP - 1);
							end
							lp_pkg::REQ_MRR: begin
								next_ca = {req_addr, lp_pkg::LP_CA_MRR};
								load = 16'(RD_GAP - 1);
							end
							lp_pkg::REQ_WR: begin
								next_ca[`LP_CA_CODE] = lp_pkg::LP_CA_WR;
								load = 16'(WR_GAP - 1);
							end
							lp_pkg::REQ_WRA: begin
								next_ca[`LP_CA_CODE] = lp_pkg::LP_CA_WR;
								next_ca[`LP_CA_AP] = 1'b1;
								next_open[req_bank] = 1'b0;
								load = 16'(WRA_GAP - 1);
							end
							lp_pkg::REQ_ACT: begin
								next_ca[`LP_CA_CODE] = lp_pkg::LP_CA_ACT;
								next_open[req_bank] = 1'b1;
							end
							lp_pkg::REQ_PRE, lp_pkg::REQ_PREA: begin
								next_ca[`LP_CA_CODE] = lp_pkg::LP_CA_PRE;
								if (req_cmd == lp_pkg::REQ_PREA) begin
									next_ca[`LP_CA_AP] = 1'b1;
									next_open = 8'h00;
								end else begin
									next_open[req_bank] = 1'b0;
								end
								load = 16'(IH_CYC - 1);
							end
							lp_pkg::REQ_REF: begin
								next_ca[`LP_CA_CODE] = lp_pkg::LP_CA_REFAB;
								load = 16'(IH_CYC - 1);
							end
							lp_pkg::REQ_MRW: begin
								next_ca = {req_addr, lp_pkg::LP_CA_MRW};
								next_op = req_op;
								if (req_addr == `LP_MA_RESET) begin
									next_init_due = 1'b0;
								end
								load = 16'(MRW_CYC - 1);
							end
							lp_pkg::REQ_ZQS, lp_pkg::REQ_ZQL, lp_pkg::REQ_ZQR: begin
								next_ca = {`LP_MA_ZQ, lp_pkg::LP_CA_MRW};
								next_state = lp_pkg::C_ZQ;
								next_zq_on = 1'b1;
								if (req_cmd == lp_pkg::REQ_ZQS) begin
									next_op = `LP_ZQ_OP_SHORT;
									next_cnt = 16'(ZQS_CYC);
								end else if (req_cmd == lp_pkg::REQ_ZQL) begin
									next_op = `LP_ZQ_OP_LONG;
									next_cnt = 16'(ZQL_CYC);
								end else begin
									next_op = `LP_ZQ_OP_RESET;
									next_cnt = 16'(ZQR_CYC);
								end
							end
							lp_pkg::REQ_PDE: begin
								next_cke = 1'b0;
								next_cs_n = 1'b1;
								next_ca = {6'h00, lp_pkg::LP_CA_NOP};
								next_state = lp_pkg::C_PD;
								next_cnt = 16'(PULSE_CYC - 1);
								next_pdt = 16'h0000;
							end
							lp_pkg::REQ_DPDE: begin
								next_cke = 1'b0;
								next_ca = {6'h00, lp_pkg::LP_CA_DPD};
								next_state = lp_pkg::C_DPD;
								next_cnt = 16'(PULSE_CYC - 1);
							end
							default: next_cs_n = 1'b1;
						endcase
					end
				end
				lp_pkg::C_ZQ: begin
					if (cnt == 16'h0001 || cnt == 16'h0000) begin
						next_state = lp_pkg::C_RUN;
						next_zq_on = 1'b0;
					end
				end
				lp_pkg::C_PD: begin
					if (pdt != 16'hffff) begin
						next_pdt = pdt + 16'h0001;
					end
					// exit on request or refresh due
					if (accept || (cnt == 16'h0000 && pdt >= 16'(PD_MAX_CYC))) begin
						next_cke = 1'b1;
						next_state = lp_pkg::C_PDX;
						next_cnt = 16'(PDX_CYC - 1);
					end
				end
				lp_pkg::C_PDX: begin
					if (cnt == 16'h0000) begin
						next_state = lp_pkg::C_RUN;
					end
				end
				lp_pkg::C_DPD: begin
					if (accept) begin
						next_cke = 1'b1;
						next_open = 8'h00;
						next_init_due = 1'b1;
						next_state = lp_pkg::C_RUN;
					end
				end
				default: next_state = lp_pkg::C_RUN;
			endcase
			if (load > next_guard) begin
				next_guard = load;
			end
		end
	end

	// Sequencer and pin registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= lp_pkg::C_RUN;
			guard <= 16'h0000;
			cnt <= 16'h0000;
			pdt <= 16'h0000;
			cke <= 1'b1;
			cs_n <= 1'b1;
			ca <= {6'h00, lp_pkg::LP_CA_NOP};
			op <= 8'h00;
			open <= 8'h00;
			init_due <= 1'b0;
			zq_on <= 1'b0;
		end else begin
			state <= next_state;
			guard <= next_guard;
			cnt <= next_cnt;
			pdt <= next_pdt;
			cke <= next_cke;
			cs_n <= next_cs_n;
			ca <= next_ca;
			op <= next_op;
			open <= next_open;
			init_due <= next_init_due;
			zq_on <= next_zq_on;
		end
	end

	// Link pins and status
	assign link.ck = ck;
	assign link.cke = cke;
	assign link.cs_n = cs_n;
	assign link.ca = ca;
	assign link.op = op;
	// tells data drivers to stay off
	assign zq_busy = zq_on;
	assign in_pd = (state == lp_pkg::C_PD);
	assign in_dpd = (state == lp_pkg::C_DPD);
	assign need_init = init_due;
	assign open_banks = open;
endmodule // lp_ctrl

// ===== tb/lp_link_checker.sv
// Assertions on the controller-to-memory link and the memory status
`timescale 1ns/1ps
module lp_link_checker #(
	parameter int PULSE_CYC = 3,
	parameter int EXIT_CYC = 2,
	parameter int ZQS_CYC = 36,
	parameter int ZQL_CYC = 180,
	parameter int ZQR_CYC = 25
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link pins
	input wire logic ck,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic [9:0] ca,
	input wire logic [7:0] op,
	// Memory status
	input wire logic pd,
	input wire logic pd_active,
	input wire logic dpd,
	input wire logic contents_lost,
	input wire logic [7:0] open_banks,
	input wire logic err
);
	logic ck_q, cke_last, next_cke_last, rise, nop;
	logic [3:0] hold, next_hold, xw, next_xw;
	logic [7:0] zq, next_zq;
	// Link rise and no-operation decode
	assign rise = ck & ~ck_q;
	assign nop = cs_n | (ca[2:0] == 3'h7);
	// Rise ages of enable level and last exit, calibration window
	always_comb begin
		next_cke_last = cke_last;
		next_hold = hold;
		next_xw = xw;
		next_zq = zq;
		if (rise) begin
			next_cke_last = cke;
			next_hold = (cke != cke_last) ? 4'h1 : hold + {3'h0, hold != 4'hf};
			next_xw = (cke & ~cke_last) ? 4'h1 : xw + {3'h0, xw != 4'hf};
			if (zq != 8'h00)
				next_zq = zq - 8'h01;
			else if (cke & ~cs_n & (ca[3:0] == 4'h0) & (ca[9:4] == 6'h0a))
				next_zq = (op == 8'h56) ? 8'(ZQS_CYC - 1) :
					(op == 8'hab) ? 8'(ZQL_CYC - 1) : 8'(ZQR_CYC - 1);
		end
	end
	// Register the helper state
	always_ff @(posedge clk) begin
		if (rst) begin
			ck_q <= 1'b0;
			cke_last <= 1'b1;
			hold <= 4'hf;
			xw <= 4'hf;
			zq <= 8'h00;
		end else begin
			ck_q <= ck;
			cke_last <= next_cke_last;
			hold <= next_hold;
			xw <= next_xw;
			zq <= next_zq;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Entry steps at a sampled link rise
	sequence s_low_in;
		rise && cke_last && !cke;
	endsequence
	sequence s_pd_in;
		s_low_in ##0 cs_n;
	endsequence
	sequence s_dpd_in;
		s_low_in ##0 (!cs_n && ca[2:0] == 3'h3);
	endsequence
	sequence s_next_nop;
		##16 (rise && nop);
	endsequence
	chk_pd_entry: assert property (s_pd_in |-> ##[1:6] pd)
		else $error("power-down not entered");
	chk_dpd_entry: assert property (s_dpd_in |-> ##[1:6] dpd)
		else $error("deep power-down not entered");
	chk_nop_after: assert property (s_low_in |-> s_next_nop)
		else $error("no no-operation after entry");
	chk_cke_pulse: assert property (rise && cke != cke_last |-> hold >= PULSE_CYC)
		else $error("enable level held too briefly");
	chk_exit_wait: assert property (rise && cke && !nop |-> xw >= EXIT_CYC)
		else $error("command too soon after exit");
	chk_zq_quiet: assert property (rise && zq != 8'h00 |-> cke && nop)
		else $error("activity during calibration");
	chk_pd_kind: assert property ($rose(pd) |-> pd_active == (open_banks != 8'h00))
		else $error("power-down kind wrong");
	chk_dpd_lost: assert property ($rose(dpd) |-> ##[0:1] contents_lost)
		else $error("contents loss not flagged");
	chk_mem_quiet: assert property (!err)
		else $error("memory flagged a violation");
endmodule // lp_link_checker

// ===== tb/tb_lpddr2_powerdown_zq_control.sv
// Bench: controller and memory on one link, plus a memory on a faulty link
`timescale 1ns/1ps
`include "lp_params.svh"
module tb_lpddr2_powerdown_zq_control;
	typedef struct {
		lp_pkg::lp_req_e cmd;
		logic [2:0] bank;
		logic [5:0] addr;
		logic [7:0] banks;
		int g;
	} lp_row_s;
	// Link cycle in ns and power-down waits in link cycles
	localparam int TCK = `LP_CLK_NS * `LP_CK_HALF * 2;
	localparam int G_RD = `LP_RD_LAT + (`LP_STRB_NS + TCK - 1) / TCK + `LP_BURST / 2 + 1;
	localparam int G_WR = `LP_WR_LAT + 1 + `LP_BURST / 2 + (`LP_WREC_NS + TCK - 1) / TCK;
	localparam int G_PRE = (`LP_HOLD_NS + TCK - 1) / TCK;
	logic clk, rst, req_valid, req_ready, zq_other_busy, zq_busy, in_pd, in_dpd, need_init;
	lp_pkg::lp_req_e req_cmd;
	logic [2:0] req_bank;
	logic [5:0] req_addr;
	logic [7:0] req_op, open_banks, m_banks;
	logic pd, pd_active, dpd, m_zq, lost, err, err2, seen2, ok, ok2;
	int err_total, total_checks;
	time t0;
	lp_pkg::lp_req_e zq_cmds[3] = '{lp_pkg::REQ_ZQS, lp_pkg::REQ_ZQL, lp_pkg::REQ_ZQR};
	// Command, bank, address, expected open banks, power-down wait
	lp_row_s rows[9] = '{
		'{lp_pkg::REQ_ACT, 3'h2, 6'h00, 8'h04, 0},
		'{lp_pkg::REQ_RD, 3'h2, 6'h00, 8'h04, G_RD},
		'{lp_pkg::REQ_WR, 3'h2, 6'h00, 8'h04, G_WR},
		'{lp_pkg::REQ_WRA, 3'h2, 6'h00, 8'h00, G_WR + 1},
		'{lp_pkg::REQ_ACT, 3'h5, 6'h00, 8'h20, 0},
		'{lp_pkg::REQ_PREA, 3'h0, 6'h00, 8'h00, G_PRE},
		'{lp_pkg::REQ_REF, 3'h0, 6'h00, 8'h00, G_PRE},
		'{lp_pkg::REQ_MRR, 3'h0, 6'h05, 8'h00, G_RD},
		'{lp_pkg::REQ_MRW, 3'h0, 6'h01, 8'h00, `LP_MRW_CYC}
	};
	lp_link_if link();
	lp_link_if link2();
	lp_ctrl #(.ZQL_CYC(10), .PD_MAX_CYC(20)) lp_ctrl_inst (.clk(clk), .rst(rst),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
		.req_op(req_op), .req_ready(req_ready), .zq_other_busy(zq_other_busy),
		.zq_busy(zq_busy), .in_pd(in_pd), .in_dpd(in_dpd), .need_init(need_init),
		.open_banks(open_banks), .link(link.ctrl));
	lp_mem #(.ZQL_CYC(10)) lp_mem_inst (.clk(clk), .rst(rst), .link(link.mem), .pd(pd),
		.pd_active(pd_active), .dpd(dpd), .zq_busy(m_zq), .contents_lost(lost),
		.open_banks(m_banks), .err(err));
	lp_mem #(.ZQL_CYC(10)) lp_mem_inst2 (.clk(clk), .rst(rst), .link(link2.mem), .pd(),
		.pd_active(), .dpd(), .zq_busy(), .contents_lost(), .open_banks(), .err(err2));
	lp_link_checker #(.ZQL_CYC(10)) lp_link_checker_inst (.clk(clk), .rst(rst),
		.ck(link.ck), .cke(link.cke), .cs_n(link.cs_n), .ca(link.ca), .op(link.op),
		.pd(pd), .pd_active(pd_active), .dpd(dpd), .contents_lost(lost),
		.open_banks(m_banks), .err(err));
	// System clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Catch a violation pulse on the faulty link
	always @(posedge clk) begin
		if (rst) seen2 <= 1'b0;
		else if (err2) seen2 <= 1'b1;
	end
	task automatic check(input logic good, input string what);
		total_checks++;
		if (!good) begin
			err_total++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	// Hold a request until taken or the limit runs out
	task automatic issue(input lp_pkg::lp_req_e c, input logic [2:0] b, input logic [5:0] a,
		input int lim, output logic taken);
		int n;
		n = 0;
		taken = 1'b0;
		@(posedge clk);
		req_cmd <= c;
		req_bank <= b;
		req_addr <= a;
		req_valid <= 1'b1;
		while (!taken && n < lim) begin
			@(negedge clk);
			taken = (req_ready === 1'b1);
			n++;
		end
		@(posedge clk);
		req_valid <= 1'b0;
	endtask
	// One link cycle on the faulty link, pins set while the clock is low
	task automatic l2(input logic e, input logic s);
		link2.cke <= e;
		link2.cs_n <= s;
		repeat (8) @(posedge clk);
		link2.ck <= 1'b1;
		repeat (8) @(posedge clk);
		link2.ck <= 1'b0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#200_000;
		err_total++;
		$display("wrong value at %0t: run hung", $time);
		results();
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req_cmd = lp_pkg::REQ_RD;
		req_bank = 3'h0;
		req_addr = 6'h00;
		req_op = 8'h00;
		zq_other_busy = 1'b0;
		link2.ck = 1'b0;
		link2.cke = 1'b1;
		link2.cs_n = 1'b1;
		link2.ca = 10'h007;
		link2.op = 8'h00;
		err_total = 0;
		total_checks = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			issue(rows[i].cmd, rows[i].bank, rows[i].addr, 2000, ok);
			t0 = $time;
			if (rows[i].g != 0) begin
				issue(lp_pkg::REQ_PDE, 3'h0, 6'h00, 2000, ok2);
				check($time - t0 >= rows[i].g * TCK && $time - t0 <= (rows[i].g + 2) * TCK,
					"power-down wait");
				repeat (30) @(posedge clk);
				check(ok2 === 1'b1 && in_pd === 1'b1 && pd === 1'b1
					&& pd_active === (rows[i].banks != 8'h00), "entry");
				issue(lp_pkg::REQ_PDX, 3'h0, 6'h00, 2000, ok2);
				repeat (30) @(posedge clk);
				check(ok2 === 1'b1 && in_pd === 1'b0 && pd === 1'b0, "exit");
			end else begin
				// Let the command reach the memory before comparing banks
				repeat (30) @(posedge clk);
			end
			check(ok === 1'b1 && open_banks === rows[i].banks && m_banks === rows[i].banks,
				"banks");
		end
		$display("row tests done");
		foreach (zq_cmds[i]) begin
			issue(zq_cmds[i], 3'h0, 6'h00, 2000, ok);
			repeat (20) @(posedge clk);
			check(ok === 1'b1 && zq_busy === 1'b1 && m_zq === 1'b1, "calibrating");
			issue(lp_pkg::REQ_ACT, 3'h1, 6'h00, 2000, ok);
			check(ok === 1'b1 && zq_busy === 1'b0, "command in calibration");
			issue(lp_pkg::REQ_PRE, 3'h1, 6'h00, 2000, ok);
		end
		zq_other_busy <= 1'b1;
		issue(lp_pkg::REQ_ZQS, 3'h0, 6'h00, 200, ok);
		check(ok === 1'b0 && zq_busy === 1'b0, "calibration overlap");
		zq_other_busy <= 1'b0;
		issue(lp_pkg::REQ_ACT, 3'h3, 6'h00, 2000, ok);
		issue(lp_pkg::REQ_ZQL, 3'h0, 6'h00, 200, ok2);
		check(ok2 === 1'b0, "calibration with open bank");
		issue(lp_pkg::REQ_PRE, 3'h3, 6'h00, 2000, ok);
		$display("calibration tests done");
		issue(lp_pkg::REQ_DPDE, 3'h0, 6'h00, 2000, ok);
		repeat (30) @(posedge clk);
		check(ok === 1'b1 && in_dpd === 1'b1 && dpd === 1'b1 && lost === 1'b1, "deep");
		issue(lp_pkg::REQ_DPDX, 3'h0, 6'h00, 2000, ok);
		issue(lp_pkg::REQ_ACT, 3'h0, 6'h00, 200, ok2);
		check(ok === 1'b1 && ok2 === 1'b0 && need_init === 1'b1 && dpd === 1'b0, "wake");
		issue(lp_pkg::REQ_MRW, 3'h0, 6'h3f, 2000, ok);
		repeat (30) @(posedge clk);
		check(ok === 1'b1 && need_init === 1'b0 && lost === 1'b0, "reinit");
		issue(lp_pkg::REQ_PDE, 3'h0, 6'h00, 2000, ok);
		repeat (500) @(posedge clk);
		check(ok === 1'b1 && in_pd === 1'b0 && pd === 1'b0, "forced exit");
		$display("deep and forced exit tests done");
		l2(1'b1, 1'b1);
		l2(1'b1, 1'b1);
		l2(1'b0, 1'b1);
		l2(1'b1, 1'b1);
		l2(1'b1, 1'b1);
		@(posedge clk);
		check(seen2 === 1'b1, "short low pulse unflagged");
		$display("fault test done");
		issue(lp_pkg::REQ_PDE, 3'h0, 6'h00, 2000, ok);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check(link.cke === 1'b1 && link.cs_n === 1'b1 && in_pd === 1'b0 && pd === 1'b0,
			"reset state");
		@(posedge clk);
		rst <= 1'b0;
		$display("reset test done");
		results();
	end
endmodule // tb_lpddr2_powerdown_zq_control
